// *** src/gis_pkg.sv ***
// Purpose: Constants for the GPIB interrupt status and mask logic.
// Assumes: Registers decoded on the low four address bits; port A and
//          port B alias onto the same registers.
// Notes:   Bit positions follow the status register layouts.

package gis_pkg;

  // ***********************************************************
  // Register offsets (low four address bits)
  // ***********************************************************
  localparam logic [3:0] OFS_DATA     = 4'h0;
  localparam logic [3:0] OFS_STAT_ONE = 4'h1;
  localparam logic [3:0] OFS_STAT_TWO = 4'h5;

  // ***********************************************************
  // First status register bit positions
  // ***********************************************************
  localparam int unsigned B1_UNKNOWN_CMD = 7;
  localparam int unsigned B1_SEC_ADDR    = 6;
  localparam int unsigned B1_TRIGGER     = 5;
  localparam int unsigned B1_END_RX      = 4;
  localparam int unsigned B1_CLEAR_REQ   = 3;
  localparam int unsigned B1_LOST_BYTE   = 2;
  localparam int unsigned B1_TX_READY    = 1;
  localparam int unsigned B1_RX_READY    = 0;

  // ***********************************************************
  // Second status / mask register bit positions
  // ***********************************************************
  localparam int unsigned B2_SUMMARY     = 7;
  localparam int unsigned B2_SRQ_SEEN    = 6;
  localparam int unsigned B2_LOCKOUT     = 5;
  localparam int unsigned B2_FAR_CTRL    = 4;
  localparam int unsigned B2_CMD_DONE    = 3;
  localparam int unsigned B2_LOCK_CHG    = 2;
  localparam int unsigned B2_REM_CHG     = 1;
  localparam int unsigned B2_ADDR_CHG    = 0;
  localparam int unsigned B2_DMA_OUT     = 5;
  localparam int unsigned B2_DMA_IN      = 4;

  // Mask bits that are interrupt enables, not DMA controls
  localparam logic [7:0] IE2_MASK       = 8'h4F;
  // Writable mask bits; bit 7 is reserved and stays zero
  localparam logic [7:0] MASK2_WR       = 8'h7F;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0] RST_BYTE       = 8'h00;

endpackage : gis_pkg

// *** src/gis_irq_status.sv ***
// Purpose: Interrupt status flags, masks and summary pin of a GPIB core.
// Assumes: All state inputs come from core logic on ref_clk; one-cycle
//          read and write strobes from the host register port.
// Notes:   Summary pin is combinational from registered flags.
//
// Contract
// - Lost-byte set when talking with no listener
// - Lost-byte set on byte write in idle
// - First status flags clear on read, reset
// - Transmit-ready set on talk-and-generate rising edge
// - Transmit-ready clears on read, state end, write
// - Receive-ready set on listen-accept unless continuous
// - Receive-ready clears on reset, reads, finish-holdoff
// - Second status and mask share offset 5/15
// - Second status bit layout, summary at top
// - Second mask bit layout, bit 7 reserved
// - Enabled status condition raises interrupt request
// - Mask never alters second status flags
// - Flag changes during second read are deferred
// - Summary is OR of enabled thirteen flags
// - Summary one drives interrupt pin

`timescale 1ns/1ps

module gis_irq_status (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            irq_pin,
  output logic            dma_out_enable,
  output logic            dma_in_enable,
  input  wire logic       talk_active,
  input  wire logic       src_delay,
  input  wire logic       data_accepted,
  input  wire logic       ready_for_data,
  input  wire logic       src_idle,
  input  wire logic       src_generate,
  input  wire logic       listen_active,
  input  wire logic       accept_data,
  input  wire logic       cont_mode,
  input  wire logic       finish_hs,
  input  wire logic       holdoff_mode,
  input  wire logic       unknown_cmd_flag,
  input  wire logic       secondary_addr_flag,
  input  wire logic       trigger_flag,
  input  wire logic       end_rx_flag,
  input  wire logic       clear_request_flag,
  input  wire logic       service_req_seen,
  input  wire logic       outbound_cmd_done,
  input  wire logic       lockout_change,
  input  wire logic       remote_change,
  input  wire logic       address_status_change,
  input  wire logic       lockout_state,
  input  wire logic       far_control_state
);

  // ***********************************************************
  // Register decode
  // ***********************************************************
  logic       rd_one;
  logic       rd_two;
  logic       wr_one;
  logic       wr_two;
  logic       rd_dir;
  logic       wr_outbound;

  // Port bit ignored: port A and port B alias
  assign rd_one      = reg_rd && (reg_addr[3:0] == gis_pkg::OFS_STAT_ONE);
  assign rd_two      = reg_rd && (reg_addr[3:0] == gis_pkg::OFS_STAT_TWO);
  assign wr_one      = reg_wr && (reg_addr[3:0] == gis_pkg::OFS_STAT_ONE);
  assign wr_two      = reg_wr && (reg_addr[3:0] == gis_pkg::OFS_STAT_TWO);
  assign rd_dir      = reg_rd && (reg_addr[3:0] == gis_pkg::OFS_DATA);
  assign wr_outbound = reg_wr && (reg_addr[3:0] == gis_pkg::OFS_DATA);

  // ***********************************************************
  // First status register
  // ***********************************************************
  logic [7:0] stat_one_q;
  logic [7:0] stat_one_d;
  logic [7:0] mask_one_q;
  logic [7:0] set_one;
  logic [7:0] clr_one;
  logic       txg_prev_q;
  logic       delay_prev_q;
  logic       no_listener;
  logic       late_write;

  assign no_listener = talk_active && src_delay && data_accepted
                       && ready_for_data;
  // Write while idle, or in the cycle delay gives way to idle
  assign late_write  = wr_outbound
                       && (src_idle || (delay_prev_q && !src_delay));

  always_comb begin
    set_one = gis_pkg::RST_BYTE;
    set_one[gis_pkg::B1_UNKNOWN_CMD] = unknown_cmd_flag;
    set_one[gis_pkg::B1_SEC_ADDR]    = secondary_addr_flag;
    set_one[gis_pkg::B1_TRIGGER]     = trigger_flag;
    set_one[gis_pkg::B1_END_RX]      = end_rx_flag;
    set_one[gis_pkg::B1_CLEAR_REQ]   = clear_request_flag;
    set_one[gis_pkg::B1_LOST_BYTE]   = no_listener || late_write;
    set_one[gis_pkg::B1_TX_READY]    = talk_active && src_generate
                                       && !txg_prev_q;
    set_one[gis_pkg::B1_RX_READY]    = listen_active && accept_data
                                       && !cont_mode;
  end

  always_comb begin
    clr_one = {8{rd_one}};
    clr_one[gis_pkg::B1_TX_READY] = rd_one || !talk_active
                                    || !src_generate
                                    || wr_outbound;
    clr_one[gis_pkg::B1_RX_READY] = rd_one || rd_dir
                                    || (finish_hs && holdoff_mode);
  end

  // Set beats clear so an event in the read cycle is not lost
  assign stat_one_d = (stat_one_q & ~clr_one) | set_one;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_one_q <= gis_pkg::RST_BYTE;
    end else begin
      stat_one_q <= stat_one_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txg_prev_q   <= 1'b0;
      delay_prev_q <= 1'b0;
    end else begin
      txg_prev_q   <= talk_active && src_generate;
      delay_prev_q <= src_delay;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_one_q <= gis_pkg::RST_BYTE;
    end else if (wr_one) begin
      mask_one_q <= reg_wdata;
    end
  end

  // ***********************************************************
  // Second status and mask registers
  // ***********************************************************
  logic [7:0] stat_two_q;
  logic [7:0] pend_two_q;
  logic [7:0] mask_two_q;
  logic [7:0] set_two;

  always_comb begin
    set_two = gis_pkg::RST_BYTE;
    set_two[gis_pkg::B2_SRQ_SEEN] = service_req_seen;
    set_two[gis_pkg::B2_CMD_DONE] = outbound_cmd_done;
    set_two[gis_pkg::B2_LOCK_CHG] = lockout_change;
    set_two[gis_pkg::B2_REM_CHG]  = remote_change;
    set_two[gis_pkg::B2_ADDR_CHG] = address_status_change;
  end

  // Events seen during a read are parked and applied afterwards
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_two_q <= gis_pkg::RST_BYTE;
    end else if (rd_two) begin
      pend_two_q <= pend_two_q | set_two;
    end else begin
      pend_two_q <= gis_pkg::RST_BYTE;
    end
  end

  // Mask plays no part in flag updates
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_two_q <= gis_pkg::RST_BYTE;
    end else if (rd_two) begin
      stat_two_q <= gis_pkg::RST_BYTE;
    end else begin
      stat_two_q <= stat_two_q | set_two | pend_two_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_two_q <= gis_pkg::RST_BYTE;
    end else if (wr_two) begin
      mask_two_q <= reg_wdata & gis_pkg::MASK2_WR;
    end
  end

  assign dma_out_enable = mask_two_q[gis_pkg::B2_DMA_OUT];
  assign dma_in_enable  = mask_two_q[gis_pkg::B2_DMA_IN];

  // ***********************************************************
  // Interrupt summary
  // ***********************************************************
  logic summary;

  // DMA control bits kept out of the sum
  assign summary = (|(stat_one_q & mask_one_q))
                   || (|(stat_two_q & mask_two_q & gis_pkg::IE2_MASK));
  // Pin follows flags in the same cycle; active high, no polarity control
  assign irq_pin = summary;

  // ***********************************************************
  // Read data
  // ***********************************************************
  logic [7:0] rdata_q;
  logic [7:0] stat_two_view;

  always_comb begin
    stat_two_view = stat_two_q;
    stat_two_view[gis_pkg::B2_SUMMARY]  = summary;
    stat_two_view[gis_pkg::B2_LOCKOUT]  = lockout_state;
    stat_two_view[gis_pkg::B2_FAR_CTRL] = far_control_state;
  end

  // Unmapped reads and the data offset return zero here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= gis_pkg::RST_BYTE;
    end else if (rd_one) begin
      rdata_q <= stat_one_q;
    end else if (rd_two) begin
      rdata_q <= stat_two_view;
    end else if (reg_rd) begin
      rdata_q <= gis_pkg::RST_BYTE;
    end
  end

  assign reg_rdata = rdata_q;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  a_lost_no_listener: assert property (
    @(posedge ref_clk) disable iff (rst)
    no_listener |=> stat_one_q[gis_pkg::B1_LOST_BYTE])
    else $error("lost-byte flag not set without listener");

  a_lost_idle_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_outbound && src_idle) |=> stat_one_q[gis_pkg::B1_LOST_BYTE])
    else $error("lost-byte flag not set on idle write");

  a_lost_transition: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_outbound && delay_prev_q && !src_delay)
    |=> stat_one_q[gis_pkg::B1_LOST_BYTE])
    else $error("lost-byte flag not set on delay-to-idle write");

  a_one_read_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_one |=> ((stat_one_q & ~$past(set_one)) == 8'h00))
    else $error("first status not cleared by read");

  a_txr_rise: assert property (
    @(posedge ref_clk) disable iff (rst)
    (talk_active && src_generate && !txg_prev_q)
    |=> stat_one_q[gis_pkg::B1_TX_READY])
    else $error("transmit-ready missed rising edge");

  a_txr_talk_end: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!talk_active || wr_outbound) && !set_one[gis_pkg::B1_TX_READY]
    |=> !stat_one_q[gis_pkg::B1_TX_READY])
    else $error("transmit-ready not cleared");

  a_txr_gen_end: assert property (
    @(posedge ref_clk) disable iff (rst)
    !src_generate |=> !stat_one_q[gis_pkg::B1_TX_READY])
    else $error("transmit-ready kept after generate ended");

  a_rxr_set_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    (listen_active && accept_data && !cont_mode)
    |=> stat_one_q[gis_pkg::B1_RX_READY])
    else $error("receive-ready not set");

  a_rxr_cont_block: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cont_mode && !stat_one_q[gis_pkg::B1_RX_READY])
    |=> !stat_one_q[gis_pkg::B1_RX_READY])
    else $error("receive-ready set in continuous mode");

  a_rxr_dir_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rd_dir && !set_one[gis_pkg::B1_RX_READY])
    |=> !stat_one_q[gis_pkg::B1_RX_READY])
    else $error("receive-ready not cleared by data read");

  a_rxr_finish_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    (finish_hs && holdoff_mode && !set_one[gis_pkg::B1_RX_READY])
    |=> !stat_one_q[gis_pkg::B1_RX_READY])
    else $error("receive-ready not cleared by finish in holdoff");

  a_two_port_b: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_two && reg_addr[4])
    |=> (mask_two_q == ($past(reg_wdata) & gis_pkg::MASK2_WR)))
    else $error("second mask write through port B lost");

  a_two_read_data: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_two |=> (reg_rdata[gis_pkg::B2_SUMMARY] == $past(summary))
               && (reg_rdata[gis_pkg::B2_LOCKOUT] == $past(lockout_state)))
    else $error("second status read layout wrong");

  a_mask_reserved: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_two |=> !mask_two_q[7])
    else $error("reserved mask bit stored");

  a_dma_follow: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_two |=> (dma_out_enable == $past(reg_wdata[gis_pkg::B2_DMA_OUT])))
    else $error("DMA-out enable does not follow mask write");

  a_mask_no_alter: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_two && !rd_two && set_two == 8'h00 && pend_two_q == 8'h00)
    |=> stat_two_q == $past(stat_two_q))
    else $error("mask write altered status flags");

  a_two_set_free: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rd_two |=> ((stat_two_q & $past(set_two)) == $past(set_two)))
    else $error("second status event not recorded");

  a_defer_apply: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rd_two && set_two != 8'h00) ##1 !rd_two
    |=> ((stat_two_q & $past(set_two, 2)) == $past(set_two, 2)))
    else $error("deferred second status event lost");

  a_irq_enabled: assert property (
    @(posedge ref_clk) disable iff (rst)
    (stat_two_q[gis_pkg::B2_SRQ_SEEN] && mask_two_q[gis_pkg::B2_SRQ_SEEN])
    || (stat_one_q[gis_pkg::B1_RX_READY] && mask_one_q[gis_pkg::B1_RX_READY])
    |-> irq_pin)
    else $error("enabled flag did not raise interrupt");

  a_irq_dma_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    (stat_one_q == 8'h00 && stat_two_q == 8'h00) |-> !irq_pin)
    else $error("interrupt without any flag");

endmodule : gis_irq_status

// *** tb/gis_core_model.sv ***
// Purpose: Stand-in for the GPIB core state machines beside the block.
// Assumes: Bench sets state levels and one-cycle events.
// Notes:   Idle core during reset; idle and delay kept exclusive, generate is not.
`timescale 1ns/1ps
module gis_core_model (
  input  wire logic        rst,
  input  wire logic [11:0] lv,
  input  wire logic [10:0] ev,
  output logic      [11:0] lv_o,
  output logic      [10:0] ev_o
);
  always_comb begin
    lv_o = rst ? 12'h000 : lv;
    ev_o = rst ? 11'h000 : ev;
    // Idle and delay never overlap in a real source
    if (lv_o[4]) lv_o[1] = 1'b0;
  end
endmodule : gis_core_model

// *** tb/gis_irq_status_tb.sv ***
// Purpose: Self-checking bench for the interrupt status and mask logic.
// Assumes: lv bits 0..11 talk,dly,dac,rfd,idle,gen,lst,acc,cont,hold,lok,rem
// Notes:   ev bits 0..4 stat1 sets, 5..9 stat2 sets, 10 finish handshake.
`timescale 1ns/1ps
module gis_irq_status_tb;
  logic        ref_clk, rst, reg_rd, reg_wr, irq_pin, dmo, dmi;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [11:0] lv, l;
  logic [10:0] ev, e;
  int          bad_count, check_count;
  logic [7:0]  m2 [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40};

  gis_core_model gis_core_model_inst (.rst(rst), .lv(lv), .ev(ev),
    .lv_o(l), .ev_o(e));
  gis_irq_status gis_irq_status_inst (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .dma_out_enable(dmo), .dma_in_enable(dmi),
    .talk_active(l[0]), .src_delay(l[1]), .data_accepted(l[2]),
    .ready_for_data(l[3]), .src_idle(l[4]), .src_generate(l[5]),
    .listen_active(l[6]), .accept_data(l[7]), .cont_mode(l[8]),
    .holdoff_mode(l[9]), .lockout_state(l[10]), .far_control_state(l[11]),
    .clear_request_flag(e[0]), .end_rx_flag(e[1]), .trigger_flag(e[2]),
    .secondary_addr_flag(e[3]), .unknown_cmd_flag(e[4]),
    .address_status_change(e[5]), .remote_change(e[6]),
    .lockout_change(e[7]), .outbound_cmd_done(e[8]),
    .service_req_seen(e[9]), .finish_hs(e[10]));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ***********************************************************
  // Bus and compare helpers
  // ***********************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic setl(input logic [11:0] v);
    @(posedge ref_clk);
    lv <= v;
  endtask : setl
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic irq(input logic v);
    @(posedge ref_clk);
    #1 chk({7'h00, irq_pin}, {7'h00, v});
  endtask : irq

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_lost;
    setl(12'h00F); setl(12'h000);
    rd(5'h01, 8'h04);
    rd(5'h01, 8'h00);
    setl(12'h010); wr(5'h00, 8'h55); setl(12'h000);
    rd(5'h01, 8'h04);
    setl(12'h002);
    @(posedge ref_clk);
    lv <= 12'h000; reg_wr <= 1'b1; reg_addr <= 5'h00;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    rd(5'h01, 8'h04);
    wr(5'h00, 8'h55);
    rd(5'h01, 8'h00);
    $display("test lost byte done");
  endtask : t_lost
  task automatic t_tx;
    wr(5'h01, 8'h02); setl(12'h021);
    irq(1'b1);
    rd(5'h01, 8'h02);
    rd(5'h01, 8'h00);
    setl(12'h000); setl(12'h021);
    irq(1'b1);
    setl(12'h001);
    irq(1'b0);
    setl(12'h021);
    irq(1'b1);
    wr(5'h00, 8'hAA);
    irq(1'b0);
    wr(5'h01, 8'h00); setl(12'h000);
    $display("test transmit ready done");
  endtask : t_tx
  task automatic t_rx;
    wr(5'h01, 8'h01); setl(12'h0C0); setl(12'h000);
    irq(1'b1);
    rd(5'h05, 8'h80);
    rd(5'h00, 8'h00);
    irq(1'b0);
    setl(12'h1C0); setl(12'h000);
    irq(1'b0);
    setl(12'h0C0); setl(12'h200);
    irq(1'b1);
    pulse(10);
    irq(1'b0);
    wr(5'h01, 8'h00); setl(12'h000);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      rd(5'h01, 8'h08 << i);
    end
    $display("test receive ready done");
  endtask : t_rx
  task automatic t_stat2;
    wr(5'h15, 8'h7F);
    irq(1'b0);
    chk({6'h00, dmo, dmi}, 8'h03);
    for (int i = 0; i < 5; i++) begin
      pulse(5 + i);
      irq(1'b1);
      rd(5'h05, 8'h80 | m2[i]);
    end
    setl(12'hC00);
    rd(5'h15, 8'h30);
    setl(12'h000); wr(5'h05, 8'h00); pulse(5);
    irq(1'b0);
    chk({6'h00, dmo, dmi}, 8'h00);
    rd(5'h15, 8'h01);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= 5'h05; ev[6] <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0; ev[6] <= 1'b0;
    #1 chk(reg_rdata, 8'h00);
    rd(5'h05, 8'h02);
    $display("test second status done");
  endtask : t_stat2
  task automatic t_reset;
    wr(5'h05, 8'h7F);
    wr(5'h01, 8'hFF);
    pulse(9);
    pulse(0);
    irq(1'b1);
    chk({6'h00, dmo, dmi}, 8'h03);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    irq(1'b0);
    chk({6'h00, dmo, dmi}, 8'h00);
    rd(5'h01, 8'h00);
    rd(5'h05, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    results();
  end

  initial begin
    rst = 1'b1; reg_rd = 1'b0; reg_wr = 1'b0; reg_addr = 5'h00;
    reg_wdata = 8'h00; lv = 12'h000; ev = 11'h000;
    bad_count = 0; check_count = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(5'h01, 8'h00);
    rd(5'h05, 8'h00);
    irq(1'b0);
    t_lost();
    t_tx();
    t_rx();
    t_stat2();
    t_reset();
    results();
  end
endmodule : gis_irq_status_tb
